// File: dv/pdm_assertions.sv
// Checker: port-level assertions for power-down control
`timescale 1ns/100ps
module pdm_assertions (
  input wire logic I_CLK, // Clock
  input wire logic I_RST, // Reset
  input wire logic [3:0] I_AVS_ADDRESS, // Address
  input wire logic I_AVS_READ, // Read
  input wire logic I_AVS_WRITE, // Write
  input wire logic [31:0] I_AVS_WRITEDATA, // Wdata
  input wire logic [3:0] I_AVS_BYTEENABLE, // Lanes
  input wire logic [31:0] O_AVS_READDATA, // Rdata
  input wire logic O_AVS_WAITREQUEST, // Stall
  input wire logic I_IRQ_ENABLED, // Irq
  input wire logic O_CPU_CLK_EN, // Cpu gate
  input wire logic O_IRQ_LOGIC_CLK_EN, // Irq gate
  input wire logic O_DMA_CLK_EN, // Dma gate
  input wire logic O_PLL_OUT_EN, // Pll out
  input wire logic O_PLL_IN_EN, // Pll in
  input wire logic O_HOST_PORT_EN, // Host
  input wire logic O_PCI_EN, // Pci
  input wire logic O_CPU_HALTED // Halted
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  logic [1:0] age;
  logic [1:0] next_age;
  // ==========================================================
  // Edges since reset, saturating: straps settle by the third
  always_comb begin
    next_age = (age == 2'h3) ? age : age + 2'h1;
  end
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      age <= 2'h0;
    end else begin
      age <= next_age;
    end
  end
  sequence s_halt_req;
    I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == 4'h0
      && I_AVS_BYTEENABLE[1] && I_AVS_WRITEDATA[15:10] == 6'h09;
  endsequence
  property p_one_wait;
    (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST;
  endproperty
  property p_read_idle;
    O_AVS_WAITREQUEST |-> O_AVS_READDATA == 32'h0;
  endproperty
  property p_halt_gates;
    O_CPU_HALTED |-> !O_CPU_CLK_EN && O_IRQ_LOGIC_CLK_EN && O_DMA_CLK_EN;
  endproperty
  property p_pll_in;
    !O_PLL_IN_EN |-> !O_PLL_OUT_EN && !O_CPU_HALTED;
  endproperty
  property p_pll_held;
    !O_PLL_OUT_EN |=> !O_PLL_OUT_EN;
  endproperty
  property p_straps;
    age == 2'h3 |-> O_PCI_EN != O_HOST_PORT_EN && $stable(O_PCI_EN);
  endproperty
  property p_wake;
    O_CPU_HALTED && I_IRQ_ENABLED |-> ##[1:2] (!O_CPU_HALTED && O_CPU_CLK_EN);
  endproperty
  property p_entry;
    s_halt_req |-> ##[1:10] O_CPU_HALTED;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("no answer");
  a_read_idle: assert property (p_read_idle) else $error("stray rdata");
  a_halt_gates: assert property (p_halt_gates) else $error("bad gates");
  a_pll_in: assert property (p_pll_in) else $error("pll in alone");
  a_pll_held: assert property (p_pll_held) else $error("pll woke");
  a_straps: assert property (p_straps) else $error("strap moved");
  a_wake: assert property (p_wake) else $error("no wake");
  a_entry: assert property (p_entry) else $error("no halt");
endmodule : pdm_assertions
bind pdm_power_down_mode_control pdm_assertions i_chk (.I_CLK, .I_RST,
  .I_AVS_ADDRESS, .I_AVS_READ, .I_AVS_WRITE, .I_AVS_WRITEDATA,
  .I_AVS_BYTEENABLE, .O_AVS_READDATA, .O_AVS_WAITREQUEST, .I_IRQ_ENABLED,
  .O_CPU_CLK_EN, .O_IRQ_LOGIC_CLK_EN, .O_DMA_CLK_EN, .O_PLL_OUT_EN,
  .O_PLL_IN_EN, .O_HOST_PORT_EN, .O_PCI_EN, .O_CPU_HALTED);

// File: dv/pdm_core_model.sv
// Partner: interrupt source of the halted processor core
`timescale 1ns/100ps
module pdm_core_model #(
  parameter int DLY = 3
) (
  input wire logic i_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_halted, // Core halted
  input wire logic [1:0] i_mode, // 1 enabled irq, 2 any only
  output logic o_irq_any, // Any irq
  output logic o_irq_enabled // Enabled irq
);
  logic [3:0] cnt;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst || !i_halted) begin
      cnt <= 4'h0;
    end else if (cnt != DLY[3:0]) begin
      cnt <= cnt + 4'h1;
    end
    o_irq_any <= !i_rst && i_halted && cnt == DLY[3:0] && i_mode != 2'h0;
    o_irq_enabled <= !i_rst && i_halted && cnt == DLY[3:0] && i_mode == 2'h1;
  end
endmodule : pdm_core_model

// File: dv/test_pdm_power_down_mode_control.sv
// Testbench: register and sleep-mode scenarios for power-down control
`timescale 1ns/100ps
module test_pdm_power_down_mode_control;
  logic clk, rst, rd, wr, irq_any, irq_en, wait_rq, cpu_en, irq_clk, dma_en;
  logic pll_o, pll_i, host, wide, pci, net, halted;
  logic [3:0] addr, be;
  logic [31:0] wdata, rdata, q;
  logic [6:0] periph;
  logic [6:0] pats [2] = '{7'h55, 7'h2A};
  logic [1:0] mode;
  logic [2:0] obs;
  logic pci_strap, width_strap, net_strap;
  int miscompares, n_checks;
  assign obs = {pll_i, pll_o, halted};
  pdm_power_down_mode_control i_dut (.I_CLK(clk), .I_RST(rst),
    .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
    .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(wait_rq), .I_PCI_SELECT_STRAP(pci_strap),
    .I_HOST_WIDTH_STRAP(width_strap), .I_NET_SELECT_STRAP(net_strap),
    .I_IRQ_ANY(irq_any),
    .I_IRQ_ENABLED(irq_en), .O_CPU_CLK_EN(cpu_en), .O_IRQ_LOGIC_CLK_EN(irq_clk),
    .O_DMA_CLK_EN(dma_en), .O_PLL_OUT_EN(pll_o), .O_PLL_IN_EN(pll_i),
    .O_HOST_PORT_EN(host), .O_HOST_PORT_WIDE(wide), .O_PCI_EN(pci),
    .O_NET_NET_SELECT_STRAP(net), .O_PERIPH_EN(periph), .O_CPU_HALTED(halted));
  pdm_core_model i_core (.i_clk(clk), .i_rst(rst), .i_halted(halted),
    .i_mode(mode), .o_irq_any(irq_any), .o_irq_enabled(irq_en));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wait_rq !== 1'b0 && n < 20);
    if (n == 20) begin
      miscompares++;
      give_verdict();
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic wait_for(input int sel, input logic v);
    int n;
    for (n = 0; n < 40 && obs[sel] !== v; n++) @(posedge clk);
    if (n == 40) begin
      miscompares++;
      give_verdict();
    end
  endtask : wait_for
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset
  task automatic sleep(input logic [5:0] code, input logic [1:0] m);
    mode <= m;
    bus(1'b1, pdm_pkg::OFS_CPU_CONTROL_STATUS, {16'h0, code, 10'h0});
  endtask : sleep
  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    mode = 2'h0;
    miscompares = 0;
    n_checks = 0;
    pci_strap = 1'b1;
    width_strap = 1'b0;
    net_strap = 1'b1;
    be = 4'hF;
    do_reset();
    // Strap outputs settle on the second edge after release
    repeat (3) @(posedge clk);
    check({pci, host, wide, net}, 4'h9);
    check({cpu_en, irq_clk, dma_en, pll_o, pll_i, halted}, 6'h3E);
    bus(1'b0, pdm_pkg::OFS_CPU_CONTROL_STATUS, 32'h0);
    check(q, pdm_pkg::CSR_RESET);
    bus(1'b0, pdm_pkg::OFS_STATUS, 32'h0);
    check(q[5:0], 6'h28);
    bus(1'b0, 4'hC, 32'h0);
    check(q, 32'h0);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, pdm_pkg::OFS_PERIPH_SELECT, {25'h0, pats[i]});
      bus(1'b0, pdm_pkg::OFS_PERIPH_SELECT, 32'h0);
      check(q[6:0], pats[i]);
      check(periph, pats[i]);
    end
    sleep(6'h1F, 2'h0);
    bus(1'b0, pdm_pkg::OFS_CPU_CONTROL_STATUS, 32'h0);
    check(q[15:10], 6'h1F);
    repeat (14) @(posedge clk);
    check(obs, 3'h6);
    sleep(pdm_pkg::SLEEP_HALT_ENABLED, 2'h2);
    wait_for(0, 1'b1);
    check({cpu_en, irq_clk, dma_en}, 3'h3);
    repeat (10) @(posedge clk);
    check(halted, 1'b1);
    mode <= 2'h1;
    wait_for(0, 1'b0);
    check(cpu_en, 1'b1);
    bus(1'b0, pdm_pkg::OFS_CPU_CONTROL_STATUS, 32'h0);
    check(q[15:10], pdm_pkg::SLEEP_NONE);
    sleep(pdm_pkg::SLEEP_HALT_ANY, 2'h2);
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    check(cpu_en, 1'b1);
    sleep(pdm_pkg::SLEEP_PLL_OUT, 2'h2);
    wait_for(1, 1'b0);
    repeat (10) @(posedge clk);
    check({pll_o, pll_i, irq_clk, dma_en, cpu_en, periph}, 12'h42A);
    bus(1'b0, pdm_pkg::OFS_CPU_CONTROL_STATUS, 32'h0);
    check(q[15:10], pdm_pkg::SLEEP_PLL_OUT);
    // Second strap set, taken only by the mid-run reset
    pci_strap <= 1'b0;
    width_strap <= 1'b1;
    net_strap <= 1'b0;
    do_reset();
    repeat (3) @(posedge clk);
    check(pll_o, 1'b1);
    check({pci, host, wide, net}, 4'h6);
    sleep(pdm_pkg::SLEEP_PLL_IN, 2'h2);
    wait_for(2, 1'b0);
    check(pll_o, 1'b0);
    do_reset();
    give_verdict();
  end
endmodule : test_pdm_power_down_mode_control

// File: hw/pdm_entry_timer.sv
// Module: counts the delay between a sleep request and its effect
`timescale 1ns/100ps
module pdm_entry_timer #(
  parameter int DELAY = pdm_pkg::ENTRY_DELAY_CYCLES
) (
  input wire logic i_clk,   // Core clock
  input wire logic i_rst,   // Async reset, high
  input wire logic i_start, // Restart the count
  input wire logic i_run,   // Count while high
  output logic o_done       // Pulse when the delay elapses
);
  logic [3:0] count;
  logic [3:0] next_count;
  logic next_done;

  always_comb begin
    next_count = count;
    next_done = 1'b0;
    if (i_start) begin
      // Load edge and done register are part of the DELAY edges
      next_count = 4'(DELAY - 2);
    end else if (i_run) begin
      if (count == 4'h0) begin
        next_done = 1'b1;
      end else begin
        next_count = count - 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count <= 4'h0;
      o_done <= 1'b0;
    end else begin
      count <= next_count;
      o_done <= next_done;
    end
  end
endmodule : pdm_entry_timer

// File: hw/pdm_pkg.sv
// Package: register map, sleep field layout and codes for power-down control
package pdm_pkg;
  // ==========================================================
  // Register offsets (byte addresses, word aligned)
  localparam logic [3:0] OFS_CPU_CONTROL_STATUS = 4'h0;
  localparam logic [3:0] OFS_PERIPH_SELECT = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  // ==========================================================
  // Sleep field of cpu_control_status
  localparam int SLEEP_LSB = 10;
  localparam int SLEEP_MSB = 15;
  localparam int BIT_CPU_HALT = 10;
  localparam int BIT_PLL_OUT_HALT = 11;
  localparam int BIT_PLL_IN_HALT = 12;
  localparam int BIT_WAKE_ENABLED = 13;
  localparam int BIT_WAKE_ANY = 14;
  localparam int BIT_SLEEP_RSVD = 15;
  localparam logic [5:0] SLEEP_NONE = 6'h00;
  localparam logic [5:0] SLEEP_HALT_ENABLED = 6'h09;
  localparam logic [5:0] SLEEP_HALT_ANY = 6'h11;
  localparam logic [5:0] SLEEP_PLL_OUT = 6'h1A;
  localparam logic [5:0] SLEEP_PLL_IN = 6'h1C;
  // ==========================================================
  // Reset values and timing
  localparam logic [31:0] CSR_RESET = 32'h0000_0000;
  localparam logic [6:0] PERIPH_SELECT_RESET = 7'h00;
  localparam int ENTRY_DELAY_CYCLES = 9;
  // Peripheral select bit positions
  localparam int PS_AUDIO_0 = 0;
  localparam int PS_SERIAL_0 = 1;
  localparam int PS_SERIAL_1 = 2;
  localparam int PS_VIDEO_0 = 3;
  localparam int PS_VIDEO_1 = 4;
  localparam int PS_VIDEO_2 = 5;
  localparam int PS_I2C_0 = 6;
  localparam int PS_WIDTH = 7;
  // Strap bits
  localparam int ST_PCI = 0;
  localparam int ST_HOST_WIDTH = 1;
  localparam int ST_NET = 2;
  typedef enum logic [2:0] {
    ST_RUN, ST_PENDING, ST_CPU_HALT, ST_PLL_OUT, ST_PLL_IN
  } pdm_state_type;
endpackage : pdm_pkg

// File: hw/pdm_power_down_mode_control.sv
// Module: power-down mode control with Avalon-MM register slave
`timescale 1ns/100ps
module pdm_power_down_mode_control (
  input wire logic I_CLK,                 // Core clock, 25 MHz
  input wire logic I_RST,                 // Async reset, high
  input wire logic [3:0] I_AVS_ADDRESS,   // Byte address
  input wire logic I_AVS_READ,            // Read request
  input wire logic I_AVS_WRITE,           // Write request
  input wire logic [31:0] I_AVS_WRITEDATA, // Write data
  input wire logic [3:0] I_AVS_BYTEENABLE, // Byte lanes
  output logic [31:0] O_AVS_READDATA,     // Read data
  output logic O_AVS_WAITREQUEST,         // Stall request
  input wire logic I_PCI_SELECT_STRAP,    // PCI select strap
  input wire logic I_HOST_WIDTH_STRAP,    // Host width strap
  input wire logic I_NET_SELECT_STRAP,    // Net MAC select strap
  input wire logic I_IRQ_ANY,             // Any interrupt pending
  input wire logic I_IRQ_ENABLED,         // Enabled interrupt pending
  output logic O_CPU_CLK_EN,              // Gate for CPU clock
  output logic O_IRQ_LOGIC_CLK_EN,        // Gate for interrupt logic
  output logic O_DMA_CLK_EN,              // Gate for DMA and memory
  output logic O_PLL_OUT_EN,              // PLL output runs
  output logic O_PLL_IN_EN,               // Core input clock to PLL
  output logic O_HOST_PORT_EN,            // Host port enable
  output logic O_HOST_PORT_WIDE,          // Host port full width
  output logic O_PCI_EN,                  // PCI enable
  output logic O_NET_NET_SELECT_STRAP,              // Net MAC and mgmt enable
  output logic [6:0] O_PERIPH_EN,         // Peripheral select enables
  output logic O_CPU_HALTED               // CPU halt in force
);
  // ==========================================================
  // Register state
  logic [31:0] cpu_control_status;
  logic [31:0] next_cpu_control_status;
  logic [6:0] peripheral_select_config;
  logic [6:0] next_peripheral_select_config;
  logic [2:0] straps;
  logic [2:0] next_straps;
  logic straps_taken;
  logic next_straps_taken;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic sleep_write;
  logic [5:0] sleep_mode_field;
  pdm_pkg::pdm_state_type state;
  pdm_pkg::pdm_state_type next_state;
  pdm_pkg::pdm_state_type target;
  logic timer_done;
  logic wake;
  logic wake_any;

  // One wait cycle per access: answer lands on the second edge
  always_comb begin
    next_waitrequest = 1'b1;
    if ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST) begin
      next_waitrequest = 1'b0;
    end
  end

  assign sleep_write = I_AVS_WRITE && !O_AVS_WAITREQUEST
    && I_AVS_ADDRESS == pdm_pkg::OFS_CPU_CONTROL_STATUS
    && I_AVS_BYTEENABLE[1];

  always_comb begin
    next_cpu_control_status = cpu_control_status;
    next_peripheral_select_config = peripheral_select_config;
    next_readdata = 32'h0000_0000;
    if (I_AVS_WRITE && !O_AVS_WAITREQUEST) begin
      unique case (I_AVS_ADDRESS)
        pdm_pkg::OFS_CPU_CONTROL_STATUS: begin
          for (int b = 0; b < 4; b++) begin
            if (I_AVS_BYTEENABLE[b]) begin
              next_cpu_control_status[b*8 +: 8] = I_AVS_WRITEDATA[b*8 +: 8];
            end
          end
        end
        pdm_pkg::OFS_PERIPH_SELECT: begin
          if (I_AVS_BYTEENABLE[0]) begin
            next_peripheral_select_config =
              I_AVS_WRITEDATA[pdm_pkg::PS_WIDTH-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (state == pdm_pkg::ST_CPU_HALT && wake) begin
      next_cpu_control_status[pdm_pkg::SLEEP_MSB:pdm_pkg::SLEEP_LSB] =
        pdm_pkg::SLEEP_NONE;
    end
    // Taken on the request edge so data stands while waitrequest is low
    if (I_AVS_READ && O_AVS_WAITREQUEST) begin
      unique case (I_AVS_ADDRESS)
        pdm_pkg::OFS_CPU_CONTROL_STATUS: begin
          next_readdata = cpu_control_status;
        end
        pdm_pkg::OFS_PERIPH_SELECT: begin
          next_readdata = {25'h0, peripheral_select_config};
        end
        pdm_pkg::OFS_STATUS: begin
          next_readdata = {26'h0, straps, 3'(state)};
        end
        default: begin
          next_readdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // straps caught once after reset release
  always_comb begin
    next_straps = straps;
    next_straps_taken = 1'b1;
    if (!straps_taken) begin
      next_straps = {I_NET_SELECT_STRAP, I_HOST_WIDTH_STRAP,
                     I_PCI_SELECT_STRAP};
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cpu_control_status <= pdm_pkg::CSR_RESET;
      peripheral_select_config <= pdm_pkg::PERIPH_SELECT_RESET;
      straps <= 3'h0;
      straps_taken <= 1'b0;
      O_AVS_READDATA <= 32'h0000_0000;
      O_AVS_WAITREQUEST <= 1'b1;
    end else begin
      cpu_control_status <= next_cpu_control_status;
      peripheral_select_config <= next_peripheral_select_config;
      straps <= next_straps;
      straps_taken <= next_straps_taken;
      O_AVS_READDATA <= next_readdata;
      O_AVS_WAITREQUEST <= next_waitrequest;
    end
  end

  // ==========================================================
  // Mode sequencer

  assign sleep_mode_field =
    cpu_control_status[pdm_pkg::SLEEP_MSB:pdm_pkg::SLEEP_LSB];

  always_comb begin
    unique case (sleep_mode_field)
      pdm_pkg::SLEEP_HALT_ENABLED: target = pdm_pkg::ST_CPU_HALT;
      pdm_pkg::SLEEP_HALT_ANY: target = pdm_pkg::ST_CPU_HALT;
      pdm_pkg::SLEEP_PLL_OUT: target = pdm_pkg::ST_PLL_OUT;
      pdm_pkg::SLEEP_PLL_IN: target = pdm_pkg::ST_PLL_IN;
      // Reserved codes act as no power-down
      default: target = pdm_pkg::ST_RUN;
    endcase
  end

  assign wake_any =
    sleep_mode_field[pdm_pkg::BIT_WAKE_ANY - pdm_pkg::SLEEP_LSB];
  assign wake = I_IRQ_ENABLED || (wake_any && I_IRQ_ANY);

  pdm_entry_timer #(
    .DELAY(pdm_pkg::ENTRY_DELAY_CYCLES)
  ) u_entry_timer (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_start(sleep_write),
    .i_run(state == pdm_pkg::ST_PENDING),
    .o_done(timer_done)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      pdm_pkg::ST_RUN: begin
        if (sleep_write) begin
          next_state = pdm_pkg::ST_PENDING;
        end
      end
      pdm_pkg::ST_PENDING: begin
        if (sleep_write) begin
          next_state = pdm_pkg::ST_PENDING;
        end else if (timer_done) begin
          next_state = target;
        end
      end
      pdm_pkg::ST_CPU_HALT: begin
        if (wake) begin
          next_state = pdm_pkg::ST_RUN;
        end
      end
      pdm_pkg::ST_PLL_OUT: next_state = pdm_pkg::ST_PLL_OUT;
      pdm_pkg::ST_PLL_IN: next_state = pdm_pkg::ST_PLL_IN;
      default: next_state = pdm_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state <= pdm_pkg::ST_RUN;
      O_CPU_CLK_EN <= 1'b1;
      O_IRQ_LOGIC_CLK_EN <= 1'b1;
      O_DMA_CLK_EN <= 1'b1;
      O_PLL_OUT_EN <= 1'b1;
      O_PLL_IN_EN <= 1'b1;
      O_CPU_HALTED <= 1'b0;
      O_HOST_PORT_EN <= 1'b0;
      O_HOST_PORT_WIDE <= 1'b0;
      O_PCI_EN <= 1'b0;
      O_NET_NET_SELECT_STRAP <= 1'b0;
      O_PERIPH_EN <= 7'h00;
    end else begin
      state <= next_state;
      O_CPU_CLK_EN <= next_state != pdm_pkg::ST_CPU_HALT
        && next_state != pdm_pkg::ST_PLL_OUT
        && next_state != pdm_pkg::ST_PLL_IN;
      O_IRQ_LOGIC_CLK_EN <= next_state != pdm_pkg::ST_PLL_OUT
        && next_state != pdm_pkg::ST_PLL_IN;
      // Memory keeps contents; only its clock stops in PLL halts
      O_DMA_CLK_EN <= next_state != pdm_pkg::ST_PLL_OUT
        && next_state != pdm_pkg::ST_PLL_IN;
      O_PLL_OUT_EN <= next_state != pdm_pkg::ST_PLL_OUT
        && next_state != pdm_pkg::ST_PLL_IN;
      O_PLL_IN_EN <= next_state != pdm_pkg::ST_PLL_IN;
      O_CPU_HALTED <= next_state == pdm_pkg::ST_CPU_HALT;
      // strap-based enables, then register-based peripheral enables; PCI and host port share pins
      O_PCI_EN <= straps_taken && straps[pdm_pkg::ST_PCI];
      O_HOST_PORT_EN <= straps_taken && !straps[pdm_pkg::ST_PCI];
      O_HOST_PORT_WIDE <= straps_taken && straps[pdm_pkg::ST_HOST_WIDTH];
      O_NET_NET_SELECT_STRAP <= straps_taken && straps[pdm_pkg::ST_NET];
      O_PERIPH_EN <= peripheral_select_config;
    end
  end
endmodule : pdm_power_down_mode_control
